//--- logic/mic_defines.svh
// Register indices, field positions, reset values and timing counts of the interrupt controller
`ifndef MIC_DEFINES_SVH
`define MIC_DEFINES_SVH

// ****************************************
// Register indices (byte address = index * 4)
// ****************************************
`define MIC_IDX_EDGE_SEL   10'h0EE
`define MIC_IDX_IEN_HIGH   10'h0E0
`define MIC_IDX_IEN_LOW    10'h0E1
`define MIC_IDX_IRQ_HIGH   10'h0E2
`define MIC_IDX_IRQ_LOW    10'h0E3
`define MIC_IDX_SRC_FLAG   10'h0E4
`define MIC_IDX_STATUS     10'h0E5
`define MIC_IDX_PORT_FUNC  10'h0E6
`define MIC_IDX_VECTOR     10'h0E7

// ****************************************
// Source indices, highest priority first
// ****************************************
`define MIC_NSRC           16
`define MIC_SRC_SERIAL_UNIT_0      4
`define MIC_SRC_SERIAL_UNIT_1      5
`define MIC_SRC_SIO        6
`define MIC_SRC_TMR0       7
`define MIC_SRC_ADC        12
`define MIC_SRC_WDTWT      13
`define MIC_SRC_BIT        14
`define MIC_SRC_BRK        4'hF

// ****************************************
// Shared source flag bits
// ****************************************
`define MIC_SF_WDT         0
`define MIC_SF_WT          1
`define MIC_SF_U0TX        2
`define MIC_SF_U0RX        3
`define MIC_SF_U1TX        4
`define MIC_SF_U1RX        5

// ****************************************
// Status word bits and reset values
// ****************************************
`define MIC_PSW_I          2
`define MIC_PSW_B          4
`define MIC_RST_BYTE       8'h00
`define MIC_RST_PEND       15'h0000

// ****************************************
// Edge modes and timing
// ****************************************
`define MIC_EDGE_FALL      2'h1
`define MIC_EDGE_RISE      2'h2
`define MIC_EDGE_BOTH      2'h3
`define MIC_ACCEPT_CYCLES  8
`define MIC_MIN_LATENCY    12
`define MIC_VEC_BASE       16'hFFE0
`define MIC_VEC_TCALL0     16'hFFDE

`endif

//--- logic/mic_pkg.sv
// Types shared by the interrupt controller modules
package mic_pkg;
	typedef enum logic [4:0] {
		MIC_IDLE = 5'b00001,
		MIC_POLL = 5'b00010,
		MIC_WAIT = 5'b00100,
		MIC_SEQ  = 5'b01000,
		MIC_CALL = 5'b10000
	} mic_state_t;
endpackage

//--- logic/mic_edge_det.sv
// Edge detectors for the external interrupt lines
`timescale 1ns/100ps
`default_nettype none
`include "mic_defines.svh"
module mic_edge_det #(
	parameter int N = 4
) (
	// Clock and reset
	input  wire logic           clk,
	input  wire logic           arst_n,
	input  wire logic           ce,
	// Lines and setup
	input  wire logic [N-1:0]   line,
	input  wire logic [2*N-1:0] mode,
	input  wire logic [N-1:0]   sel,
	// Detected edges
	output logic      [N-1:0]   evt
);
	logic [N-1:0] prev;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			prev <= '0;
		else if (ce)
			prev <= line & sel;
	end

	genvar g;
	generate
		for (g = 0; g < N; g++) begin : g_line
			logic now_v;
			assign now_v = line[g] & sel[g]; // [RULE13]
			// Mode 00 leaves the line silent
			assign evt[g] = (mode[2*g+1] & now_v & ~prev[g])
				| (mode[2*g] & ~now_v & prev[g]); // [RULE12]
		end
	endgenerate
endmodule
`default_nettype wire

//--- logic/mic_irq_ctrl.sv
// Interrupt controller: pending flags, priority, acceptance sequence and APB registers
//
// Operation
// RULE1: Acceptance pushes PC and status word; accumulator and general registers are not saved.
// RULE2: Break instruction raises a software interrupt of lowest priority.
// RULE3: Break uses the table-call-zero vector and sets the break flag.
// RULE4: Watchdog and watch timer share a vector, each with its own shared flag.
// RULE5: Serial unit 0 transmit and receive share a vector, distinct shared flags.
// RULE6: Serial unit 1 transmit and receive share a vector, distinct shared flags.
// RULE7: Shared flags survive reads; only a software write clears them.
// RULE8: Simultaneous requests of different priority: higher one is served first.
// RULE9: Equal priority requests are resolved by a fixed hardware polling order.
// RULE10: Acceptance clears master enable; setting it again allows nesting.
// RULE11: Edge selection register at index 0EE sets each external input's sensitivity.
// RULE12: Each external input detects rising, falling or both edges.
// RULE13: A pin acts as interrupt input only when its port function bit is 1.
// RULE14: Edges latch into pending flags each cycle; polling sees them next cycle.
// RULE15: An enabled polled request makes the next operation a call to its vector.
// RULE16: At least twelve cycles pass from request to first service instruction.
// RULE17: Acceptance sequence lasts 8 clock cycles after the current instruction.
// RULE18: Acceptance clears only the accepted pending flag; others are held.
// RULE19: Disabled sources never accepted; cleared master enable blocks all maskable ones.
// RULE20: Priority: ext 0-3, serial 0, serial 1, sync serial, timers, ADC, WDT, BIT, break.
// RULE21: Return from interrupt restores status word, hence the master enable flag.
`timescale 1ns/100ps
`default_nettype none
`include "mic_defines.svh"
module mic_irq_ctrl #(
	parameter int NEXT = 4
) (
	// Clock, reset, enable
	input  wire logic        CLK,
	input  wire logic        ARST_N,
	input  wire logic        CE,
	// APB slave
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [11:0] PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	// External lines and peripheral events
	input  wire logic [NEXT-1:0] EXT_IRQ_LINE,
	input  wire logic        U0_TX_DONE,
	input  wire logic        U0_RX_DONE,
	input  wire logic        U1_TX_DONE,
	input  wire logic        U1_RX_DONE,
	input  wire logic        SIO_DONE,
	input  wire logic [4:0]  TMR_MATCH,
	input  wire logic        ADC_DONE,
	input  wire logic        WDT_MATCH,
	input  wire logic        WT_MATCH,
	input  wire logic        BIT_OVF,
	// CPU core
	input  wire logic        INSTR_DONE,
	input  wire logic        SOFT_BREAK_INSTR,
	input  wire logic        RETURN_FROM_IRQ,
	input  wire logic [7:0]  POP_STATUS,
	input  wire logic [15:0] PC,
	output logic             ACCEPT_BUSY,
	output logic             STACK_WR,
	output logic      [7:0]  STACK_DATA,
	output logic             VECTOR_LOAD,
	output logic      [15:0] VECTOR_ADDR
);
	// ****************************************
	// Declarations
	// ****************************************
	mic_pkg::mic_state_t state;
	logic [7:0]  edge_sel, port_func, ien_high, ien_low, status_word, saved_status;
	logic [14:0] pend;
	logic [5:0]  src_flag;
	logic        brk_pend;
	logic [3:0]  win_idx;
	logic [3:0]  acc_cnt;
	logic [4:0]  lat_cnt;
	logic [NEXT-1:0] ext_evt;
	logic [14:0] set_evt, ien;
	logic [15:0] cand;
	logic        iflag, bflag, wr_en, setup, accept, idx_ok;
	logic [9:0]  idx;

	// First set bit wins: fixed polling order
	function automatic logic [3:0] first_idx(input logic [15:0] v); // [RULE9]
		first_idx = `MIC_SRC_BRK;
		for (int i = `MIC_NSRC - 1; i >= 0; i--)
			if (v[i])
				first_idx = 4'(i);
	endfunction

	function automatic logic [7:0] idx_val(input logic [9:0] a);
		unique case (a)
			`MIC_IDX_EDGE_SEL:  idx_val = edge_sel;
			`MIC_IDX_IEN_HIGH:  idx_val = ien_high;
			`MIC_IDX_IEN_LOW:   idx_val = ien_low;
			`MIC_IDX_IRQ_HIGH:  idx_val = pend[7:0];
			`MIC_IDX_IRQ_LOW:   idx_val = {1'b0, pend[14:8]};
			`MIC_IDX_SRC_FLAG:  idx_val = {2'b00, src_flag};
			`MIC_IDX_STATUS:    idx_val = status_word;
			`MIC_IDX_PORT_FUNC: idx_val = port_func;
			`MIC_IDX_VECTOR:    idx_val = {4'h0, win_idx};
			default:            idx_val = `MIC_RST_BYTE;
		endcase
	endfunction

	// ****************************************
	// External edge detection
	// ****************************************
	mic_edge_det #(.N(NEXT)) u_edge (
		.clk  (CLK),
		.arst_n(ARST_N),
		.ce   (CE),
		.line (EXT_IRQ_LINE),
		.mode (edge_sel[2*NEXT-1:0]), // [RULE11]
		.sel  (port_func[NEXT-1:0]),
		.evt  (ext_evt)
	);

	// ****************************************
	// APB slave
	// ****************************************
	assign idx     = PADDR[11:2];
	assign idx_ok  = (idx == `MIC_IDX_EDGE_SEL) || (idx >= `MIC_IDX_IEN_HIGH && idx <= `MIC_IDX_VECTOR);
	assign setup   = CE && PSEL && !PENABLE;
	assign wr_en   = CE && PSEL && PENABLE && PWRITE && idx_ok;
	// Single-wait-free slave: answer in the access cycle
	assign PREADY  = 1'b1;
	assign PSLVERR = PSEL && PENABLE && !idx_ok;

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N)
			PRDATA <= '0;
		else if (setup)
			PRDATA <= {24'h000000, idx_val(idx)};
	end

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			edge_sel  <= `MIC_RST_BYTE;
			port_func <= `MIC_RST_BYTE;
			ien_high  <= `MIC_RST_BYTE;
			ien_low   <= `MIC_RST_BYTE;
		end else if (wr_en) begin
			if (idx == `MIC_IDX_EDGE_SEL)
				edge_sel <= PWDATA[7:0]; // [RULE11]
			if (idx == `MIC_IDX_PORT_FUNC)
				port_func <= PWDATA[7:0]; // [RULE13]
			if (idx == `MIC_IDX_IEN_HIGH)
				ien_high <= PWDATA[7:0];
			if (idx == `MIC_IDX_IEN_LOW)
				ien_low <= PWDATA[7:0];
		end
	end

	// ****************************************
	// Pending and shared flags
	// ****************************************
	assign set_evt[NEXT-1:0]     = ext_evt; // [RULE14]
	assign set_evt[`MIC_SRC_SERIAL_UNIT_0] = U0_TX_DONE | U0_RX_DONE; // [RULE5]
	assign set_evt[`MIC_SRC_SERIAL_UNIT_1] = U1_TX_DONE | U1_RX_DONE; // [RULE6]
	assign set_evt[`MIC_SRC_SIO]   = SIO_DONE;
	assign set_evt[`MIC_SRC_ADC-1:`MIC_SRC_TMR0] = TMR_MATCH;
	assign set_evt[`MIC_SRC_ADC]   = ADC_DONE;
	assign set_evt[`MIC_SRC_WDTWT] = WDT_MATCH | WT_MATCH; // [RULE4]
	assign set_evt[`MIC_SRC_BIT]   = BIT_OVF;

	// Set wins over both the software clear and the acceptance clear
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N)
			pend <= `MIC_RST_PEND;
		else if (CE) begin
			for (int i = 0; i < `MIC_NSRC - 1; i++) begin
				if (set_evt[i])
					pend[i] <= 1'b1;
				else if (accept && win_idx == 4'(i))
					pend[i] <= 1'b0; // [RULE18]
				else if (wr_en && idx == (i < 8 ? `MIC_IDX_IRQ_HIGH : `MIC_IDX_IRQ_LOW) && PWDATA[i % 8])
					pend[i] <= 1'b0;
			end
		end
	end

	// Write one to clear; reading leaves the flags alone
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N)
			src_flag <= '0;
		else if (CE) begin
			src_flag <= (src_flag & ~((wr_en && idx == `MIC_IDX_SRC_FLAG) ? PWDATA[5:0] : 6'h00)) // [RULE7]
				| {U1_RX_DONE, U1_TX_DONE, U0_RX_DONE, U0_TX_DONE, WT_MATCH, WDT_MATCH}; // [RULE4] [RULE5] [RULE6]
		end
	end

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N)
			brk_pend <= 1'b0;
		else if (CE) begin
			if (SOFT_BREAK_INSTR)
				brk_pend <= 1'b1; // [RULE2]
			else if (accept && win_idx == `MIC_SRC_BRK)
				brk_pend <= 1'b0;
		end
	end

	// ****************************************
	// Status word: master enable and break flag
	// ****************************************
	assign iflag = status_word[`MIC_PSW_I];
	assign bflag = status_word[`MIC_PSW_B];

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N)
			status_word <= `MIC_RST_BYTE;
		else if (CE) begin
			if (accept) begin
				status_word[`MIC_PSW_I] <= 1'b0; // [RULE10]
				status_word[`MIC_PSW_B] <= (win_idx == `MIC_SRC_BRK); // [RULE3]
			end else if (RETURN_FROM_IRQ)
				status_word <= POP_STATUS; // [RULE21]
			else if (wr_en && idx == `MIC_IDX_STATUS)
				status_word <= PWDATA[7:0]; // [RULE10]
		end
	end

	// ****************************************
	// Priority and acceptance sequence
	// ****************************************
	assign ien  = {ien_low[6:0], ien_high};
	// Break is outside the masks; everything else needs its enable and the master flag
	assign cand = {brk_pend, pend & ien & {15{iflag}}}; // [RULE19] [RULE20]
	assign accept = CE && state == mic_pkg::MIC_WAIT && INSTR_DONE && cand[win_idx];
	assign ACCEPT_BUSY = (state == mic_pkg::MIC_SEQ) || (state == mic_pkg::MIC_CALL);

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			state   <= mic_pkg::MIC_IDLE;
			win_idx <= 4'h0;
			acc_cnt <= 4'h0;
			lat_cnt <= 5'h00;
		end else if (CE) begin
			if (lat_cnt != 5'(`MIC_MIN_LATENCY))
				lat_cnt <= lat_cnt + 5'h01;
			unique case (state)
				mic_pkg::MIC_IDLE: begin
					lat_cnt <= 5'h01;
					// Flags latched last cycle are polled here
					if (|cand)
						state <= mic_pkg::MIC_POLL; // [RULE14]
				end
				mic_pkg::MIC_POLL: begin
					win_idx <= first_idx(cand); // [RULE8] [RULE20]
					state   <= (|cand) ? mic_pkg::MIC_WAIT : mic_pkg::MIC_IDLE;
				end
				mic_pkg::MIC_WAIT: begin
					// Dropped enable or master flag abandons the request
					if (!cand[win_idx])
						state <= mic_pkg::MIC_IDLE; // [RULE19]
					else if (INSTR_DONE) begin
						state   <= mic_pkg::MIC_SEQ; // [RULE15]
						acc_cnt <= 4'h0;
					end
				end
				mic_pkg::MIC_SEQ: begin
					acc_cnt <= acc_cnt + 4'h1;
					if (acc_cnt == 4'(`MIC_ACCEPT_CYCLES - 1))
						state <= mic_pkg::MIC_CALL; // [RULE17]
				end
				mic_pkg::MIC_CALL: begin
					if (lat_cnt == 5'(`MIC_MIN_LATENCY))
						state <= mic_pkg::MIC_IDLE; // [RULE16]
				end
				default: state <= mic_pkg::MIC_IDLE;
			endcase
		end
	end

	// Only PC and status are pushed; software saves the rest
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			STACK_WR   <= 1'b0;
			STACK_DATA <= `MIC_RST_BYTE;
			saved_status <= `MIC_RST_BYTE;
		end else if (CE) begin
			// Status is captured before acceptance clears the master flag
			if (accept)
				saved_status <= status_word; // [RULE21]
			STACK_WR <= state == mic_pkg::MIC_SEQ && acc_cnt < 4'h3; // [RULE1]
			unique case (acc_cnt)
				4'h0:    STACK_DATA <= PC[15:8];
				4'h1:    STACK_DATA <= PC[7:0];
				default: STACK_DATA <= saved_status;
			endcase
		end
	end

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			VECTOR_LOAD <= 1'b0;
			VECTOR_ADDR <= 16'h0000;
		end else if (CE) begin
			VECTOR_LOAD <= state == mic_pkg::MIC_CALL && lat_cnt == 5'(`MIC_MIN_LATENCY); // [RULE15]
			VECTOR_ADDR <= (win_idx == `MIC_SRC_BRK) ? `MIC_VEC_TCALL0 // [RULE3]
				: `MIC_VEC_BASE - {11'h000, win_idx, 1'b0};
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!ARST_N);

	sequence s_accept;
		accept;
	endsequence
	sequence s_pushes;
		STACK_WR [*3] ##1 !STACK_WR;
	endsequence

	a_accept_iflag: assert property (s_accept |=> !iflag) else $error("master enable not cleared"); // [RULE10]
	a_push_three: assert property (s_accept ##1 CE |=> s_pushes) else $error("wrong push count"); // [RULE1]
	a_seq_length: assert property (s_accept |-> ##9 state == mic_pkg::MIC_CALL) else $error("bad sequence length"); // [RULE17]
	a_brk_flag: assert property (s_accept and win_idx == `MIC_SRC_BRK |=> bflag) else $error("break flag not set"); // [RULE3]
	a_mask_gate: assert property (s_accept and win_idx != `MIC_SRC_BRK |-> ien[win_idx] && iflag)
		else $error("masked source accepted"); // [RULE19]
	a_prio_top: assert property (CE && state == mic_pkg::MIC_POLL && cand[0] |=> win_idx == 4'h0)
		else $error("higher priority skipped"); // [RULE8]
	a_flag_sticky: assert property (CE && !(wr_en && idx == `MIC_IDX_SRC_FLAG) |=> (src_flag & $past(src_flag)) == $past(src_flag))
		else $error("shared flag lost"); // [RULE7]
	a_ext_latch: assert property (CE && ext_evt[0] |=> pend[0]) else $error("edge not latched"); // [RULE14]
	a_return_from_irq_restore: assert property (CE && RETURN_FROM_IRQ && !accept |=> iflag == $past(POP_STATUS[`MIC_PSW_I]))
		else $error("status not restored"); // [RULE21]
	a_min_latency: assert property (VECTOR_LOAD |-> $past(lat_cnt) == 5'(`MIC_MIN_LATENCY))
		else $error("vector too early"); // [RULE16]
endmodule
`default_nettype wire

//--- test/mic_cpu_model.sv
// Behavioural CPU core facing the interrupt controller
`timescale 1ns/100ps
`default_nettype none
module mic_cpu_model #(
	parameter int GAP = 3
) (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        arst_n,
	// Controller side
	input  wire logic        accept_busy,
	input  wire logic        stack_wr,
	input  wire logic [7:0]  stack_data,
	output logic             instr_done
);
	int         cnt;
	logic [7:0] pushed[$];
	// Core stalls its instruction flow while the controller runs a call
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt        <= 0;
			instr_done <= 1'b0;
		end else begin
			cnt        <= (cnt >= GAP - 1) ? 0 : cnt + 1;
			instr_done <= (cnt == 0) && !accept_busy;
		end
	end
	// Stack area: pushes kept in arrival order
	always @(posedge clk) begin
		if (stack_wr === 1'b1) begin
			pushed.push_back(stack_data);
		end
	end
endmodule
`default_nettype wire

//--- test/tb.sv
// Self-checking bench of the interrupt controller
`timescale 1ns/100ps
`default_nettype none
`include "mic_defines.svh"
module tb;
	logic        clk, arst_n, psel, penable, pwrite, pready, pslverr;
	logic        instr_done, busy, stk_wr, vld;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [3:0]  ext;
	logic [15:0] ev, pc, vaddr;
	logic [7:0]  stk_d;
	int          num_errors, n_tests, cycles, cyc, exp_sf, n, evb[6];

	mic_irq_ctrl #(.NEXT(4)) dut (.CLK(clk), .ARST_N(arst_n), .CE(1'b1), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.EXT_IRQ_LINE(ext), .U0_TX_DONE(ev[0]), .U0_RX_DONE(ev[1]), .U1_TX_DONE(ev[2]), .U1_RX_DONE(ev[3]),
		.SIO_DONE(ev[4]), .TMR_MATCH(ev[9:5]), .ADC_DONE(ev[10]), .WDT_MATCH(ev[11]), .WT_MATCH(ev[12]),
		.BIT_OVF(ev[13]), .INSTR_DONE(instr_done), .SOFT_BREAK_INSTR(ev[14]), .RETURN_FROM_IRQ(ev[15]),
		.POP_STATUS(8'h04), .PC(pc), .ACCEPT_BUSY(busy), .STACK_WR(stk_wr), .STACK_DATA(stk_d),
		.VECTOR_LOAD(vld), .VECTOR_ADDR(vaddr));
	mic_cpu_model #(.GAP(3)) cpu (.clk(clk), .arst_n(arst_n), .accept_busy(busy), .stack_wr(stk_wr),
		.stack_data(stk_d), .instr_done(instr_done));

	// ****************************************
	// Clock, timeout and checking
	// ****************************************
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			end_of_test();
		end
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// ****************************************
	// Bus and event tasks
	// ****************************************
	task automatic apb(input logic w, input logic [9:0] idx, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= {idx, 2'b00};
		pwdata  <= wd;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [9:0] idx, input logic [7:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, idx, {24'h0, d}, r, e);
	endtask
	task automatic rdc(input logic [9:0] idx, input logic [7:0] x);
		logic [31:0] r;
		logic        e;
		apb(1'b0, idx, 32'h0, r, e);
		chk(r, {24'h0, x});
	endtask
	task automatic pulse(input logic [15:0] m);
		@(posedge clk);
		ev <= m;
		@(posedge clk);
		ev <= 16'h0;
	endtask
	// Cycle count from the edge that samples the request to the vector load
	task automatic wait_vec(input int lim, output int c);
		c = -1;
		for (int i = 1; i <= lim; i++) begin
			@(posedge clk);
			ev <= 16'h0;
			if (vld === 1'b1) begin
				c = i;
				break;
			end
		end
	endtask
	function automatic logic [15:0] vexp(input int i);
		return 16'hFFE0 - 16'(2 * i);
	endfunction

	// ****************************************
	// Scenarios
	// ****************************************
	initial begin
		logic [31:0] r;
		logic        e;
		{psel, penable, pwrite, paddr, pwdata, ext, ev} = '0;
		arst_n = 1'b0;
		void'($urandom(32'h5857f42b));
		pc = 16'($urandom);
		evb = '{11, 12, 0, 1, 2, 3};
		repeat (4) @(posedge clk);
		arst_n <= 1'b1;
		rdc(`MIC_IDX_STATUS, 8'h00);
		rdc(`MIC_IDX_EDGE_SEL, 8'h00);
		rdc(`MIC_IDX_SRC_FLAG, 8'h00);
		apb(1'b0, 10'h0F0, 32'h0, r, e);
		chk({31'h0, e}, 32'h1);
		chk(r, 32'h0);
		r = $urandom;
		wr(`MIC_IDX_EDGE_SEL, r[7:0]);
		rdc(`MIC_IDX_EDGE_SEL, r[7:0]);
		$display("test registers done");
		// Shared flags: master flag off so nothing is accepted
		for (int k = 0; k < 6; k++) begin
			pulse(16'h1 << evb[k]);
			exp_sf |= 1 << k;
			rdc(`MIC_IDX_SRC_FLAG, 8'(exp_sf));
			rdc(`MIC_IDX_SRC_FLAG, 8'(exp_sf));
		end
		rdc(`MIC_IDX_IRQ_HIGH, 8'h30);
		rdc(`MIC_IDX_IRQ_LOW, 8'h20);
		wr(`MIC_IDX_SRC_FLAG, 8'h01);
		rdc(`MIC_IDX_SRC_FLAG, 8'h3E);
		wr(`MIC_IDX_SRC_FLAG, 8'h3F);
		wr(`MIC_IDX_IRQ_HIGH, 8'hFF);
		wr(`MIC_IDX_IRQ_LOW, 8'hFF);
		$display("test shared flags done");
		// Serial 0 and timer 0 together: serial wins, timer waits
		wr(`MIC_IDX_IEN_HIGH, 8'hFF);
		wr(`MIC_IDX_IEN_LOW, 8'h7F);
		wr(`MIC_IDX_STATUS, 8'h04);
		cpu.pushed.delete();
		@(posedge clk);
		ev <= 16'h0021;
		wait_vec(100, cyc);
		chk(32'(cyc >= 13), 32'h1);
		chk(vaddr, vexp(4));
		chk({cpu.pushed[0], cpu.pushed[1], cpu.pushed[2]}, {pc, 8'h04});
		rdc(`MIC_IDX_STATUS, 8'h00);
		rdc(`MIC_IDX_IRQ_HIGH, 8'h80);
		wait_vec(40, cyc);
		chk(cyc, -1);
		@(posedge clk);
		ev <= 16'h8000;
		wait_vec(60, cyc);
		chk(vaddr, vexp(7));
		$display("test priority done");
		// Disabled source is held, then taken once enabled
		wr(`MIC_IDX_IEN_HIGH, 8'h00);
		wr(`MIC_IDX_STATUS, 8'h04);
		pulse(16'h0004);
		wait_vec(40, cyc);
		chk(cyc, -1);
		rdc(`MIC_IDX_IRQ_HIGH, 8'h20);
		@(posedge clk);
		ev <= 16'h0;
		wr(`MIC_IDX_IEN_HIGH, 8'h20);
		wait_vec(60, cyc);
		chk(vaddr, vexp(5));
		$display("test masking done");
		// External edges in the falling, rising and both modes, then pin released to the port
		wr(`MIC_IDX_STATUS, 8'h00);
		wr(`MIC_IDX_PORT_FUNC, 8'h0F);
		for (int m = 1; m < 4; m++) begin
			n = $urandom % 4;
			wr(`MIC_IDX_EDGE_SEL, 8'(m << (2 * n)));
			wr(`MIC_IDX_IRQ_HIGH, 8'hFF);
			ext[n] <= 1'b1;
			rdc(`MIC_IDX_IRQ_HIGH, m[1] ? 8'(1 << n) : 8'h00);
			wr(`MIC_IDX_IRQ_HIGH, 8'hFF);
			ext[n] <= 1'b0;
			rdc(`MIC_IDX_IRQ_HIGH, m[0] ? 8'(1 << n) : 8'h00);
		end
		wr(`MIC_IDX_PORT_FUNC, 8'h00);
		wr(`MIC_IDX_EDGE_SEL, 8'hFF);
		wr(`MIC_IDX_IRQ_HIGH, 8'hFF);
		ext <= 4'hF;
		rdc(`MIC_IDX_IRQ_HIGH, 8'h00);
		ext <= 4'h0;
		wr(`MIC_IDX_PORT_FUNC, 8'h0F);
		wr(`MIC_IDX_IEN_HIGH, 8'hFF);
		wr(`MIC_IDX_STATUS, 8'h04);
		@(posedge clk);
		ext[n] <= 1'b1;
		wait_vec(100, cyc);
		chk(32'(cyc >= 13), 32'h1);
		chk(vaddr, vexp(n));
		$display("test external done");
		// Break together with basic interval timer: break comes last
		wr(`MIC_IDX_STATUS, 8'h04);
		@(posedge clk);
		ev <= 16'h6000;
		wait_vec(100, cyc);
		chk(vaddr, vexp(14));
		wait_vec(100, cyc);
		chk(vaddr, 16'hFFDE);
		rdc(`MIC_IDX_STATUS, 8'h10);
		$display("test break done");
		end_of_test();
	end
endmodule
`default_nettype wire
